// ==== src/ciex_pkg.sv ====
// shared constants and types for the instruction execution subset
package ciex_pkg;
  localparam int CIEX_DATA_W = 8;
  localparam int CIEX_FADDR_W = 7;
  localparam int CIEX_PC_W = 13;
  localparam int CIEX_LIT_W = 11;
  localparam int CIEX_LATCH_LO = 3;
  localparam logic [7:0] CIEX_ZERO_BYTE = 8'h00;
  localparam logic [7:0] CIEX_WDT_CLEAR = 8'h00;
  localparam logic [7:0] CIEX_ACC_RST = 8'h00;
  localparam logic [12:0] CIEX_PC_RST = 13'h0000;
  localparam logic CIEX_DEST_ACC = 1'b0;
  localparam logic CIEX_DEST_FILE = 1'b1;

  typedef enum logic [2:0] {
    CIEX_OP_WDTCLR = 3'b000,
    CIEX_OP_CALL = 3'b001,
    CIEX_OP_COMPF = 3'b010,
    CIEX_OP_CLRFILE = 3'b011,
    CIEX_OP_CLRACC = 3'b100,
    CIEX_OP_DECREMENT_FILE_OP = 3'b101,
    CIEX_OP_DECSKIP = 3'b110,
    CIEX_OP_NONE = 3'b111
  } ciex_op_t;

  typedef enum logic [1:0] {
    CIEX_ST_EXEC = 2'b00,
    CIEX_ST_CALL2 = 2'b01,
    CIEX_ST_IDLE = 2'b10
  } ciex_state_t;

  typedef struct packed {
    ciex_op_t op;
    logic dest;
    logic [6:0] fileAddr;
    logic [10:0] literal;
  } ciex_instr_t;

  typedef struct packed {
    logic we;
    logic [6:0] addr;
    logic [7:0] data;
  } ciex_fwrite_t;
endpackage

// ==== src/ciex_core.sv ====
// execution of watchdog clear, call, complement, clears and decrements
// Operation
// - watchdog clear zeroes counter
// - watchdog clear sets expired and sleep flags
// - call pushes program counter plus one
// - call loads literal and latch bits 4:3
// - call takes two cycles, flags untouched
// - destination bit selects accumulator or file
// - complement inverts file, updates zero flag
// - clear file writes zero, sets zero flag
// - clear accumulator writes zero, sets zero flag
// - decrement subtracts one, updates zero flag
// - decrement-skip on zero discards next, idles
// - nonzero decrement-skip continues without idle
module ciex_core
  import ciex_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic instrValid,
  input wire ciex_instr_t instr,
  input wire logic [7:0] fileReadData,
  input wire logic [7:0] pcHighLatch,
  output logic [6:0] fileReadAddr,
  output ciex_fwrite_t fileWrite,
  output logic [7:0] accumulator,
  output logic [12:0] programCounter,
  output logic stackPush,
  output logic [12:0] stackTop,
  output logic watchdogClear,
  output logic [7:0] watchdogCounter,
  output logic watchdogExpiredSet,
  output logic sleepEnteredSet,
  output logic zeroFlagWe,
  output logic zeroFlagValue,
  output logic instrAccept,
  output logic fetchDiscard
);
  // fileReadData is combinational for fileReadAddr driven by the fetch path
  ciex_state_t state_q, state_d;
  ciex_fwrite_t fileWrite_q, fileWrite_d;
  logic [7:0] acc_q, acc_d;
  logic [12:0] pc_q, pc_d;
  logic push_q, push_d;
  logic [12:0] tos_q, tos_d;
  logic wdtClr_q, wdtClr_d;
  logic [7:0] wdt_q, wdt_d;
  logic zWe_q, zWe_d;
  logic zVal_q, zVal_d;
  logic accept_q, accept_d;
  logic discard_q, discard_d;
  logic [7:0] result;
  logic writeResult;

  always_comb begin
    state_d = state_q;
    fileWrite_d = '{we: 1'b0, addr: instr.fileAddr, data: CIEX_ZERO_BYTE};
    acc_d = acc_q;
    pc_d = pc_q;
    push_d = 1'b0;
    tos_d = tos_q;
    wdtClr_d = 1'b0;
    wdt_d = wdt_q;
    zWe_d = 1'b0;
    zVal_d = zVal_q;
    accept_d = 1'b0;
    discard_d = 1'b0;
    result = CIEX_ZERO_BYTE;
    writeResult = 1'b0;
    case (state_q)
      CIEX_ST_EXEC: begin
        if (instrValid) begin
          accept_d = 1'b1;
          pc_d = 13'(pc_q + 13'h0001);
          case (instr.op)
            CIEX_OP_WDTCLR: begin
              wdt_d = CIEX_WDT_CLEAR;
              wdtClr_d = 1'b1;
            end
            CIEX_OP_CALL: begin
              push_d = 1'b1;
              tos_d = 13'(pc_q + 13'h0001);
              pc_d = {pcHighLatch[CIEX_LATCH_LO+1:CIEX_LATCH_LO], instr.literal};
              state_d = CIEX_ST_CALL2;
            end
            CIEX_OP_COMPF: begin
              result = ~fileReadData;
              writeResult = 1'b1;
              zWe_d = 1'b1;
              zVal_d = (result == CIEX_ZERO_BYTE);
            end
            CIEX_OP_CLRFILE: begin
              fileWrite_d.we = 1'b1;
              zWe_d = 1'b1;
              zVal_d = 1'b1;
            end
            CIEX_OP_CLRACC: begin
              acc_d = CIEX_ZERO_BYTE;
              zWe_d = 1'b1;
              zVal_d = 1'b1;
            end
            CIEX_OP_DECREMENT_FILE_OP: begin
              result = 8'(fileReadData - 8'h01);
              writeResult = 1'b1;
              zWe_d = 1'b1;
              zVal_d = (result == CIEX_ZERO_BYTE);
            end
            CIEX_OP_DECSKIP: begin
              // no flag write here, the skip decision only
              result = 8'(fileReadData - 8'h01);
              writeResult = 1'b1;
              if (result == CIEX_ZERO_BYTE) begin
                discard_d = 1'b1;
                state_d = CIEX_ST_IDLE;
              end
              // nonzero: stay in exec, next word runs normally
              accept_d = 1'b1;
            end
            default: begin
              accept_d = 1'b1;
            end
          endcase
          if (writeResult) begin
            if (instr.dest == CIEX_DEST_FILE) begin
              fileWrite_d.we = 1'b1;
              fileWrite_d.data = result;
            end else begin
              acc_d = result;
            end
          end
        end
      end
      CIEX_ST_CALL2: begin
        // second call cycle flushes the fetched word
        discard_d = 1'b1;
        state_d = CIEX_ST_EXEC;
      end
      CIEX_ST_IDLE: begin
        // idle slot in place of the skipped word, pc steps past it
        discard_d = 1'b1;
        pc_d = 13'(pc_q + 13'h0001);
        state_d = CIEX_ST_EXEC;
      end
      default: begin
        state_d = CIEX_ST_EXEC;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      state_q <= CIEX_ST_EXEC;
      fileWrite_q <= '{we: 1'b0, addr: 7'h00, data: CIEX_ZERO_BYTE};
      acc_q <= CIEX_ACC_RST;
      pc_q <= CIEX_PC_RST;
      push_q <= 1'b0;
      tos_q <= CIEX_PC_RST;
      wdtClr_q <= 1'b0;
      wdt_q <= CIEX_WDT_CLEAR;
      zWe_q <= 1'b0;
      zVal_q <= 1'b0;
      accept_q <= 1'b0;
      discard_q <= 1'b0;
    end else begin
      state_q <= state_d;
      fileWrite_q <= fileWrite_d;
      acc_q <= acc_d;
      pc_q <= pc_d;
      push_q <= push_d;
      tos_q <= tos_d;
      wdtClr_q <= wdtClr_d;
      wdt_q <= wdt_d;
      zWe_q <= zWe_d;
      zVal_q <= zVal_d;
      accept_q <= accept_d;
      discard_q <= discard_d;
    end
  end

  always_comb begin
    fileReadAddr = instr.fileAddr;
  end
  assign fileWrite = fileWrite_q;
  assign accumulator = acc_q;
  assign programCounter = pc_q;
  assign stackPush = push_q;
  assign stackTop = tos_q;
  assign watchdogClear = wdtClr_q;
  assign watchdogCounter = wdt_q;
  assign watchdogExpiredSet = wdtClr_q;
  assign sleepEnteredSet = wdtClr_q;
  assign zeroFlagWe = zWe_q;
  assign zeroFlagValue = zVal_q;
  assign instrAccept = accept_q;
  assign fetchDiscard = discard_q;
endmodule

// ==== testbench/ciex_core_checker.sv ====
// port assertions for the execution subset
module ciex_core_checker
  import ciex_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire ciex_instr_t instr,
  input wire logic [7:0] fileReadData,
  input wire ciex_fwrite_t fileWrite,
  input wire logic [12:0] programCounter,
  input wire logic stackPush,
  input wire logic [12:0] stackTop,
  input wire logic watchdogClear,
  input wire logic [7:0] watchdogCounter,
  input wire logic watchdogExpiredSet,
  input wire logic sleepEnteredSet,
  input wire logic zeroFlagWe,
  input wire logic instrAccept,
  input wire logic fetchDiscard
);
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (rst);
  property p_cnt; watchdogClear |-> watchdogCounter == 8'h00; endproperty
  a_cnt: assert property (p_cnt) else $error("counter");
  property p_flg; watchdogClear |-> watchdogExpiredSet && sleepEnteredSet && !zeroFlagWe; endproperty
  a_flg: assert property (p_flg) else $error("flags");
  property p_push; stackPush |-> stackTop == $past(programCounter) + 13'h1; endproperty
  a_push: assert property (p_push) else $error("push");
  property p_tgt; stackPush |-> programCounter[10:0] == $past(instr.literal); endproperty
  a_tgt: assert property (p_tgt) else $error("target");
  property p_two; stackPush |-> !zeroFlagWe ##1 fetchDiscard && !stackPush; endproperty
  a_two: assert property (p_two) else $error("two cycles");
  property p_clr; instrAccept && $past(instr.op) == CIEX_OP_CLRFILE |->
    fileWrite.we && fileWrite.data == 8'h00 && zeroFlagWe; endproperty
  a_clr: assert property (p_clr) else $error("clear");
  property p_cmp; instrAccept && $past(instr.op) == CIEX_OP_COMPF && $past(instr.dest) |->
    fileWrite.we && fileWrite.data == ~$past(fileReadData); endproperty
  a_cmp: assert property (p_cmp) else $error("complement");
  property p_skp; instrAccept && $past(instr.op) == CIEX_OP_DECSKIP |->
    !zeroFlagWe ##1 fetchDiscard == ($past(fileReadData, 2) == 8'h01); endproperty
  a_skp: assert property (p_skp) else $error("skip");
endmodule
bind ciex_core ciex_core_checker u_chk (.core_clk(core_clk), .rst(rst), .instr(instr),
  .fileReadData(fileReadData), .fileWrite(fileWrite), .programCounter(programCounter),
  .stackPush(stackPush), .stackTop(stackTop), .watchdogClear(watchdogClear),
  .watchdogCounter(watchdogCounter), .watchdogExpiredSet(watchdogExpiredSet),
  .sleepEnteredSet(sleepEnteredSet), .zeroFlagWe(zeroFlagWe),
  .instrAccept(instrAccept), .fetchDiscard(fetchDiscard));

// ==== testbench/testbench.sv ====
// self-checking bench for the execution subset
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin err_count++; \
  $display("ERROR %0t got %h exp %h", $time, a, b); end end
module testbench
  import ciex_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk = 0, rst = 1, instrValid = 0, stackPush, watchdogClear, watchdogExpiredSet;
  logic sleepEnteredSet, zeroFlagWe, zeroFlagValue, instrAccept, fetchDiscard;
  logic [7:0] fileReadData = 8'h00, pcHighLatch = 8'h00, accExp = 8'h00;
  logic [7:0] accumulator, watchdogCounter;
  logic [12:0] programCounter, stackTop, pcExp = 13'h0000;
  logic [6:0] fileReadAddr;
  ciex_instr_t instr = '0;
  ciex_fwrite_t fileWrite;
  int err_count = 0, cmp_count = 0;
  ciex_core dut (.core_clk(core_clk), .rst(rst), .instrValid(instrValid), .instr(instr),
    .fileReadData(fileReadData), .pcHighLatch(pcHighLatch), .fileReadAddr(fileReadAddr),
    .fileWrite(fileWrite), .accumulator(accumulator), .programCounter(programCounter),
    .stackPush(stackPush), .stackTop(stackTop), .watchdogClear(watchdogClear),
    .watchdogCounter(watchdogCounter), .watchdogExpiredSet(watchdogExpiredSet),
    .sleepEnteredSet(sleepEnteredSet), .zeroFlagWe(zeroFlagWe),
    .zeroFlagValue(zeroFlagValue), .instrAccept(instrAccept), .fetchDiscard(fetchDiscard));
  task automatic summarize();
    $display("compares %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic run(input ciex_op_t op, input logic d, input logic [7:0] rd, input logic [10:0] k);
    logic [7:0] res;
    logic rmw, we, zw;
    logic [12:0] ret;
    rmw = op inside {CIEX_OP_COMPF, CIEX_OP_DECREMENT_FILE_OP, CIEX_OP_DECSKIP};
    res = op == CIEX_OP_COMPF ? ~rd : (rmw ? rd - 8'h01 : 8'h00);
    we = (rmw && d) || op == CIEX_OP_CLRFILE;
    zw = op inside {CIEX_OP_COMPF, CIEX_OP_DECREMENT_FILE_OP, CIEX_OP_CLRFILE, CIEX_OP_CLRACC};
    if ((rmw && !d) || op == CIEX_OP_CLRACC)
      accExp = res;
    ret = 13'(pcExp + 13'h0001);
    pcExp = op == CIEX_OP_CALL ? {pcHighLatch[4:3], k} : ret;
    instr = '{op, d, k[6:0], k};
    fileReadData = rd;
    instrValid = 1'h1;
    @(posedge core_clk) #1;
    instrValid = 1'h0;
    `CHK(instrAccept, 1'h1)
    `CHK(fileWrite.we, we)
    if (we) `CHK(fileWrite.data, res)
    `CHK(accumulator, accExp)
    `CHK(zeroFlagWe, zw)
    if (zw) `CHK(zeroFlagValue, res == 8'h00)
    `CHK(watchdogClear && watchdogExpiredSet, op == CIEX_OP_WDTCLR)
    `CHK(sleepEnteredSet, op == CIEX_OP_WDTCLR)
    `CHK(programCounter, pcExp)
    `CHK(fileReadAddr, k[6:0])
    if (we) `CHK(fileWrite.addr, k[6:0])
    if (op == CIEX_OP_CALL) `CHK(stackTop, ret)
    if (op == CIEX_OP_CALL) `CHK(programCounter, {pcHighLatch[4:3], k})
    // only these two may open an idle slot
    if (op inside {CIEX_OP_CALL, CIEX_OP_DECSKIP}) begin
      @(posedge core_clk) #1;
      `CHK(fetchDiscard, op == CIEX_OP_CALL || res == 8'h00)
      @(posedge core_clk) #1;
      // the idle slot steps the counter past the skipped word
      if (op == CIEX_OP_DECSKIP && res == 8'h00)
        pcExp = 13'(pcExp + 13'h0001);
      `CHK(programCounter, pcExp)
    end
  endtask
  initial begin
    forever #4 core_clk = ~core_clk;
  end
  initial begin
    ciex_op_t op;
    void'($urandom(65885));
    repeat (6) @(posedge core_clk);
    #1 rst = 0;
    pcHighLatch = 8'($urandom());
    // first after reset, so the pushed address is known
    run(CIEX_OP_CALL, 1'h0, 8'h00, 11'h7ff);
    $display("call test done");
    for (int i = 0; i < 90; i++) begin
      op = ciex_op_t'($urandom_range(7, 0));
      if (op == CIEX_OP_CALL)
        op = CIEX_OP_DECSKIP;
      run(op, 1'($urandom()), i % 3 == 0 ? 8'h01 : 8'($urandom()), 11'($urandom()));
    end
    $display("random test done");
    summarize();
  end
endmodule
